// ==== verilog/fil_pkg.sv ====
// constants for the fault flag and interrupt logic
package fil_pkg;
    // register offsets
    localparam logic [7:0] fault_flag_status_addr    = 8'h02;
    localparam logic [7:0] fault_interrupt_mask_addr = 8'h03;
    // bit positions shared by status and mask
    localparam int         overvoltage_bit           = 2;
    localparam int         overtemp_bit              = 3;
    localparam int         short_bit                 = 4;
    localparam logic [7:0] flag_field_mask           = 8'h1c;
    localparam logic [7:0] reg_reset_value           = 8'h00;
    // reset glitch filter: time and derived cycles at 25 MHz
    localparam int         clk_mhz                   = 25;
    localparam int         reset_filter_ns           = 200;
    localparam int         reset_filter_cycles       =
        (reset_filter_ns * clk_mhz + 999) / 1000;
    localparam int         filter_cnt_width          = 4;
endpackage

// ==== verilog/fil_fault_interrupt.sv ====
// fault flag latching, interrupt masking and thermal standby control
//
// Overview of operation
// - overtemp trips: shutdown, standby, set flag
// - restart only on new active write, cool
// - no interrupt when die cools down
// - cleared overtemp flag resets while still hot
// - overvoltage comparator high sets overvoltage flag
// - short protection entry sets short flag
// - flag reaches pin only when enabled
// - write one clears flag; reset clears all
// - reads and zero writes change nothing
// - reset pin glitches filtered internally
// - each overvoltage entry sets flag again
// - short fault restarts on active rewrite
`timescale 1ns/100ps
module fil_fault_interrupt
(
    // clock and resets
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       external_reset_low,
    // register access port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // standby control from mode register
    input  wire logic       active_not_standby,
    // asynchronous fault comparators
    input  wire logic       overtemp_hot,
    input  wire logic       overtemp_cool,
    input  wire logic       overvoltage_cmp,
    input  wire logic       short_cmp,
    // outputs
    output logic            standby_forced,
    output logic            soft_start_req,
    output logic            interrupt_request_low
);
    // filter limit cut to the counter's width
    localparam logic [fil_pkg::filter_cnt_width-1:0] filt_limit =
        fil_pkg::reset_filter_cycles[fil_pkg::filter_cnt_width-1:0];

    // whole block state, registered in one place
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] ext_sync;
        logic [1:0] ot_sync;
        logic [1:0] ov_sync;
        logic [1:0] sc_sync;
        logic [1:0] cool_sync;
        logic [fil_pkg::filter_cnt_width-1:0] filt_cnt;
        logic       filt_rst;
        logic       ov_prev;
        logic       sc_prev;
        logic       ot_prev;
        logic       act_prev;
        logic       thermal_latched;
        logic       short_latched;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic       soft_start;
        logic       int_req;
    } fil_state_s;

    // current and next state, plus helpers
    fil_state_s st;
    fil_state_s next_st;
    logic       srst_n;
    logic       hold_reset;
    logic       ot_now;
    logic       ov_now;
    logic       sc_now;
    logic       cool_now;
    logic       act_rise;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;

    // second flops of the synchronisers feed the logic
    assign srst_n   = st.rst_sync[1];
    assign ot_now   = st.ot_sync[1];
    assign ov_now   = st.ov_sync[1];
    assign sc_now   = st.sc_sync[1];
    assign cool_now = st.cool_sync[1];
    // internal reset: synchronised rst_n or a filtered pin low
    assign hold_reset = !srst_n || st.filt_rst;

    // next state
    always_comb
    begin
        next_st = st;
        act_rise = 1'b0;
        set_bits = 8'h00;
        clr_bits = 8'h00;
        // two-flop synchronisers for the resets and the comparator inputs
        next_st.rst_sync  = {st.rst_sync[0], 1'b1};
        next_st.ext_sync  = {st.ext_sync[0], external_reset_low};
        next_st.ot_sync   = {st.ot_sync[0], overtemp_hot};
        next_st.ov_sync   = {st.ov_sync[0], overvoltage_cmp};
        next_st.sc_sync   = {st.sc_sync[0], short_cmp};
        next_st.cool_sync = {st.cool_sync[0], overtemp_cool};
        // reset pin filter: low must persist before acting
        if (st.ext_sync[1])
        begin
            next_st.filt_cnt = '0;
            next_st.filt_rst = 1'b0;
        end
        else if (st.filt_cnt == filt_limit)
        begin
            next_st.filt_rst = 1'b1;
        end
        else
        begin
            next_st.filt_cnt = st.filt_cnt + 1'b1;
        end
        // edge memories of the overtemp, overvoltage and short comparators and the standby level
        next_st.ov_prev  = ov_now;
        next_st.sc_prev  = sc_now;
        next_st.ot_prev  = ot_now;
        next_st.act_prev = active_not_standby;
        act_rise = active_not_standby & ~st.act_prev;
        next_st.soft_start = 1'b0;
        // fault event detection
        if (ot_now && !st.ot_prev)
        begin
            set_bits[fil_pkg::overtemp_bit] = 1'b1;
        end
        if (ot_now)
        begin
            next_st.thermal_latched = 1'b1;
        end
        if (ov_now && !st.ov_prev)
        begin
            set_bits[fil_pkg::overvoltage_bit] = 1'b1;
        end
        if (sc_now && !st.sc_prev)
        begin
            set_bits[fil_pkg::short_bit] = 1'b1;
            next_st.short_latched = 1'b1;
        end
        // hot die: re-raise a cleared overtemp flag
        if ((ot_now || st.thermal_latched) && !cool_now &&
            !st.status[fil_pkg::overtemp_bit])
        begin
            set_bits[fil_pkg::overtemp_bit] = 1'b1;
        end
        // restart on a fresh active write; cooling alone does nothing
        if (act_rise)
        begin
            if (st.thermal_latched && cool_now && !ot_now)
            begin
                next_st.thermal_latched = 1'b0;
            end
            if (st.short_latched && !sc_now)
            begin
                next_st.short_latched = 1'b0;
            end
            // no restart while the die is still over the trip point
            if (!ot_now && (!st.thermal_latched || cool_now))
            begin
                next_st.soft_start = 1'b1;
            end
        end
        // register writes
        if (reg_wr && reg_addr == fil_pkg::fault_flag_status_addr)
        begin
            clr_bits = reg_wdata & fil_pkg::flag_field_mask;
        end
        // mask register write
        if (reg_wr && reg_addr == fil_pkg::fault_interrupt_mask_addr)
        begin
            next_st.mask = reg_wdata & fil_pkg::flag_field_mask;
        end
        // set wins over clear; flags hold otherwise
        next_st.status = ((st.status & ~clr_bits) | set_bits)
                         & fil_pkg::flag_field_mask;
        // read data, no side effects
        if (reg_rd)
        begin
            case (reg_addr)
                fil_pkg::fault_flag_status_addr:
                    next_st.rdata = st.status;
                fil_pkg::fault_interrupt_mask_addr:
                    next_st.rdata = st.mask;
                default:
                    next_st.rdata = 8'h00;
            endcase
        end

        // pin request from the next flags, so the pin leaves a flop
        next_st.int_req = |(next_st.status & next_st.mask);

        // internal reset clears all but the two reset synchronisers and act_prev
        if (hold_reset)
        begin
            next_st          = '0;
            next_st.status   = fil_pkg::reg_reset_value;
            next_st.mask     = fil_pkg::reg_reset_value;
            next_st.rst_sync = {st.rst_sync[0], 1'b1};
            next_st.ext_sync = {st.ext_sync[0], external_reset_low};
            next_st.act_prev = active_not_standby; // no false restart
        end
    end

    // state register; rst_n acts at once, its release is synchronised
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs from the state register, the interrupt pin through an inverter
    assign reg_rdata             = st.rdata;
    assign standby_forced        = st.thermal_latched;
    assign soft_start_req        = st.soft_start;
    assign interrupt_request_low = ~st.int_req;
endmodule

// ==== verification/fil_fault_interrupt_sva.sv ====
// checker for the fault flag and interrupt ports
`timescale 1ns/100ps
module fil_fault_interrupt_sva
(
    // all ports of the block
    input wire logic       clk, rst_n, external_reset_low, reg_wr, reg_rd,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic       active_not_standby, overtemp_hot, overtemp_cool,
    input wire logic       overvoltage_cmp, short_cmp, standby_forced,
    input wire logic       soft_start_req, interrupt_request_low
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !external_reset_low);
    // status read taken with no write beside it
    sequence s_rd_st;
        reg_rd && !reg_wr && reg_addr == fil_pkg::fault_flag_status_addr;
    endsequence
    a_read_no_clear: assert property (s_rd_st ##1 s_rd_st |=>
        (reg_rdata & $past(reg_rdata)) == $past(reg_rdata))
        else $error("flag lost by a read");
    a_unused_bits: assert property (reg_rd |=>
        (reg_rdata & ~fil_pkg::flag_field_mask) == 8'h00)
        else $error("unused status bit reads one");
    a_hot_standby: assert property (
        overtemp_hot [*8] |-> standby_forced)
        else $error("hot die not in standby");
    a_standby_holds: assert property (standby_forced &&
        !active_not_standby |=> standby_forced)
        else $error("standby left without host");
    a_start_pulse: assert property (
        soft_start_req |=> !soft_start_req)
        else $error("soft start longer than a cycle");
    a_start_cause: assert property (soft_start_req |->
        $past(active_not_standby)) else $error("soft start unasked");
    a_start_not_hot: assert property (
        soft_start_req |-> !standby_forced)
        else $error("soft start while forced");
    a_mask_off_quiet: assert property (reg_wr &&
        reg_addr == fil_pkg::fault_interrupt_mask_addr &&
        (reg_wdata & fil_pkg::flag_field_mask) == 8'h00
        |=> interrupt_request_low) else $error("masked pin low");
endmodule
bind fil_fault_interrupt fil_fault_interrupt_sva i_sva (.*);

// ==== verification/fil_host.sv ====
// host model driving register accesses and standby control
`timescale 1ns/100ps
module fil_host
(
    // register port and mode level
    input  wire logic       clk,
    output logic            reg_wr, reg_rd, active_not_standby,
    output logic      [7:0] reg_addr, reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial {reg_wr, reg_rd, active_not_standby, reg_addr, reg_wdata} = '0;
    // access held n taking edges, then the bus shows inverted values
    task automatic acc(input logic w, input logic [7:0] a, d,
                       input int n, output logic [7:0] q);
        @(posedge clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        repeat (n) @(posedge clk);
        #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
        q = reg_rdata;
    endtask
    // leaving standby is a rising level after a low one
    task automatic go(input logic v);
        @(posedge clk) #1 active_not_standby = v;
    endtask
    // bring-up writes outside this block: small fly caps, spare sinks off
    task automatic prep;
        logic [7:0] dummy;
        acc(1'b1, 8'h01, 8'h08, 1, dummy);
        acc(1'b1, 8'h05, 8'h7f, 1, dummy);
        acc(1'b1, 8'h10, 8'h00, 1, dummy);
    endtask
endmodule

// ==== verification/tb_fil_fault_interrupt.sv ====
// bench for fault latching, masking and thermal restart
`timescale 1ns/100ps
module tb_fil_fault_interrupt;
    logic clk = 0, rst_n = 0, external_reset_low = 1, overtemp_hot = 0;
    logic overtemp_cool = 1, overvoltage_cmp = 0, short_cmp = 0;
    logic reg_wr, reg_rd, active_not_standby, standby_forced;
    logic soft_start_req, interrupt_request_low;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
    logic [7:0] st = 8'h00, mk = 8'h00, lfsr = 8'h22;
    int errors = 0, check_count = 0, cyc = 0, starts = 0;
    always #20 clk = ~clk;
    fil_fault_interrupt i_dut (.*);
    fil_host i_host (.*);
    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // read through two back-to-back takes, then check data and pin
    task automatic rchk(input logic [7:0] a, e);
        i_host.acc(1'b0, a, 8'h00, 2, q);
        chk(q, e);
        chk({7'h00, interrupt_request_low}, {7'h00, ~|(st & mk)});
    endtask
    task automatic hit(input int b);
        @(posedge clk) #1;
        {short_cmp, overtemp_hot, overvoltage_cmp} = 3'b001 << (b - 2);
        overtemp_cool = !overtemp_hot;
        repeat (6) @(posedge clk);
        #1 {short_cmp, overtemp_hot, overvoltage_cmp, overtemp_cool} = 4'h1;
        st[b] = 1'b1;
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // pulse counter and hang limit
    always @(posedge clk)
    begin
        if (soft_start_req === 1'b1) starts++;
        if (++cyc == 3000)
        begin
            errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1;
        repeat (3) @(posedge clk);
        i_host.prep();
        rchk(8'h02, 8'h00);
        rchk(8'h03, 8'h00);
        rchk(8'h07, 8'h00);
        for (int j = 0; j < 6; j++)
        begin
            lfsr = nx(lfsr);
            mk = lfsr & fil_pkg::flag_field_mask;
            i_host.acc(1'b1, 8'h03, lfsr, 1, q);
            hit(j % 3 + 2);
            rchk(8'h02, st);
            rchk(8'h03, mk);
            lfsr = nx(lfsr);
            i_host.acc(1'b1, 8'h02, lfsr, 1, q);
            st = st & ~lfsr;
            rchk(8'h02, st);
        end
        $display("test flags done");
        mk = 8'h1c;
        i_host.acc(1'b1, 8'h03, mk, 1, q);
        {overtemp_hot, overtemp_cool} = 2'b10;
        repeat (8) @(posedge clk);
        st[3] = 1'b1;
        i_host.acc(1'b1, 8'h02, 8'h08, 1, q);
        rchk(8'h02, st);
        i_host.go(1'b1);
        repeat (4) @(posedge clk);
        #1 chk({7'h00, standby_forced}, 8'h01);
        {overtemp_hot, overtemp_cool} = 2'b01;
        i_host.go(1'b0);
        i_host.acc(1'b1, 8'h02, 8'h08, 1, q);
        st[3] = 1'b0;
        repeat (6) @(posedge clk);
        rchk(8'h02, st);
        i_host.go(1'b1);
        repeat (4) @(posedge clk);
        #1 chk({7'h00, standby_forced}, 8'h00);
        hit(4);
        i_host.go(1'b0);
        i_host.go(1'b1);
        repeat (4) @(posedge clk);
        #1 chk(starts[7:0], 8'h02);
        $display("test restart done");
        external_reset_low = 0;
        repeat (2) @(posedge clk);
        #1 external_reset_low = 1;
        repeat (6) @(posedge clk);
        rchk(8'h02, st);
        external_reset_low = 0;
        repeat (12) @(posedge clk);
        #1 external_reset_low = 1;
        {st, mk} = 16'h0000;
        repeat (8) @(posedge clk);
        rchk(8'h02, st);
        rchk(8'h03, mk);
        $display("test reset pin done");
        wrap_up();
    end
endmodule
